//--- core/hlib_host.sv
// Host controller receiving in-band interrupts through a bus hub
`timescale 1ns/1ns
`default_nettype none
module hlib_host import hlib_pkg::*; #(
  parameter int HALF = SCL_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic host_data_line_in,
  output logic host_data_line_out,
  output logic host_data_line_oe,
  output logic host_clock_line
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] exp_bytes(input logic pec);
    exp_bytes = pec ? BYTES_PEC : BYTES_NO_PEC;
  endfunction

  function automatic logic [15:0] addr_view(input logic [7:0] a);
    addr_view = {(a[7:4] == HUB_DEVICE_CODE), a[3:1], a[7:4], a};
  endfunction

  hlib_state_t st_reg, st_next;
  logic sda_s, eng_busy, eng_done, eng_rx;
  logic go_reg, go_next, pend_reg, pend_next, tx_reg, tx_next, stopm_reg, stopm_next;
  logic [2:0] bitc_reg, bitc_next, bytec_reg, bytec_next;
  logic [7:0] shift_reg, shift_next, addr_reg, addr_next;
  logic [7:0] mem_reg [MAX_BYTES];
  logic [7:0] mem_next [MAX_BYTES];
  logic ack_reg, ack_next, abort_pend_reg, abort_pend_next, full_pend_reg, full_pend_next;
  logic set_done, set_nack, set_abort, set_badrw;
  logic ibi_en_reg, ibi_en_next, ack_en_reg, ack_en_next, pec_reg, pec_next;
  logic [1:0] abort_after_reg, abort_after_next;
  logic done_reg, done_next, nack_reg, nack_next, abrt_reg, abrt_next;
  logic badrw_reg, badrw_next, busy_reg, busy_next;
  logic [31:0] rdata_next;
  logic [2:0] bytec_inc;
  logic [31:0] data_word;

  // ----------------------------------------------------------------
  // Pin synchronisation and bit engine
  // ----------------------------------------------------------------
  hlib_sync #(.W(1)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(host_data_line_in),
    .dout(sda_s)
  );

  hlib_bit_engine #(.HALF(HALF)) u_eng (
    .clk(clk),
    .nrst(nrst),
    .go(go_reg),
    .tx_bit(tx_reg),
    .stop_mode(stopm_reg),
    .sda_s(sda_s),
    .busy(eng_busy),
    .done(eng_done),
    .rx_bit(eng_rx),
    .scl_out(host_clock_line),
    .sda_oe(host_data_line_oe)
  );

  assign bytec_inc = bytec_reg + 3'h1;

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    go_next = 1'b0;
    pend_next = pend_reg;
    tx_next = tx_reg;
    stopm_next = stopm_reg;
    bitc_next = bitc_reg;
    bytec_next = bytec_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    ack_next = ack_reg;
    abort_pend_next = abort_pend_reg;
    full_pend_next = full_pend_reg;
    set_done = 1'b0;
    set_nack = 1'b0;
    set_abort = 1'b0;
    set_badrw = 1'b0;
    for (int i = 0; i < MAX_BYTES; i++) begin
      mem_next[i] = mem_reg[i];
    end
    // Launch one bit whenever the engine is free and the state is not M_IDLE
    if (st_reg != M_IDLE && !pend_reg && !go_reg && !eng_busy) begin
      go_next = 1'b1;
      pend_next = 1'b1;
      stopm_next = (st_reg == M_STOP);
      tx_next = (st_reg == M_ACK) ? ~ack_reg : 1'b1;
    end
    if (eng_done) begin
      pend_next = 1'b0;
    end
    unique case (st_reg)
      M_IDLE: begin
        bitc_next = '0;
        // Byte count of the last payload stays readable while idle
        abort_pend_next = 1'b0;
        full_pend_next = 1'b0;
        // Requester holds data low with clock high
        if (ibi_en_reg && !sda_s && host_clock_line && !eng_busy) begin
          st_next = M_ADDR;
        end
      end
      M_ADDR: begin
        if (eng_done) begin
          shift_next = {shift_reg[6:0], eng_rx};
          bitc_next = bitc_reg + 3'h1;
          if (bitc_reg == 3'h7) begin
            addr_next = {shift_reg[6:0], eng_rx};
            ack_next = ack_en_reg & eng_rx;
            set_badrw = ~eng_rx;
            st_next = M_ACK;
          end
        end
      end
      M_ACK: begin
        if (eng_done) begin
          bitc_next = '0;
          bytec_next = '0;
          if (ack_reg) begin
            st_next = M_DATA;
          end else begin
            set_nack = 1'b1;
            st_next = M_STOP;
          end
        end
      end
      M_DATA: begin
        if (eng_done) begin
          shift_next = {shift_reg[6:0], eng_rx};
          bitc_next = bitc_reg + 3'h1;
          if (bitc_reg == 3'h7) begin
            mem_next[bytec_reg[1:0]] = {shift_reg[6:0], eng_rx};
            st_next = M_TBIT;
          end
        end
      end
      M_TBIT: begin
        if (eng_done) begin
          bytec_next = bytec_inc;
          bitc_next = '0;
          if (!eng_rx) begin
            full_pend_next = 1'b1;
            st_next = M_STOP;
          end else if (bytec_inc >= exp_bytes(pec_reg) ||
                       (abort_after_reg != 2'h0 && bytec_inc == {1'b0, abort_after_reg})) begin
            abort_pend_next = 1'b1;
            st_next = M_STOP;
          end else begin
            st_next = M_DATA;
          end
        end
      end
      M_STOP: begin
        if (eng_done) begin
          set_done = full_pend_reg;
          set_abort = abort_pend_reg;
          st_next = M_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    data_word = '0;
    for (int i = 0; i < MAX_BYTES; i++) begin
      data_word[8*i +: 8] = mem_reg[i];
    end
  end

  // Control writes and sticky flags; a set beats a clear
  always_comb begin
    ibi_en_next = ibi_en_reg;
    ack_en_next = ack_en_reg;
    pec_next = pec_reg;
    abort_after_next = abort_after_reg;
    if (reg_wr && reg_addr == REG_CTRL) begin
      ibi_en_next = reg_wdata[CTRL_IBI_EN];
      ack_en_next = reg_wdata[CTRL_ACK_EN];
      pec_next = reg_wdata[CTRL_PEC_EN];
      abort_after_next = reg_wdata[CTRL_ABORT_LSB +: 2];
    end
    done_next = done_reg;
    nack_next = nack_reg;
    abrt_next = abrt_reg;
    badrw_next = badrw_reg;
    if (reg_wr && reg_addr == REG_STATUS) begin
      done_next = done_reg & ~reg_wdata[ST_DONE];
      nack_next = nack_reg & ~reg_wdata[ST_NACK];
      abrt_next = abrt_reg & ~reg_wdata[ST_ABORT];
      badrw_next = badrw_reg & ~reg_wdata[ST_BADRW];
    end
    done_next = done_next | set_done;
    nack_next = nack_next | set_nack;
    abrt_next = abrt_next | set_abort;
    badrw_next = badrw_next | set_badrw;
    busy_next = (st_next != M_IDLE);
    rdata_next = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: begin
          rdata_next[CTRL_IBI_EN] = ibi_en_reg;
          rdata_next[CTRL_ACK_EN] = ack_en_reg;
          rdata_next[CTRL_PEC_EN] = pec_reg;
          rdata_next[CTRL_ABORT_LSB +: 2] = abort_after_reg;
        end
        REG_STATUS: begin
          rdata_next[ST_BUSY] = busy_reg;
          rdata_next[ST_DONE] = done_reg;
          rdata_next[ST_NACK] = nack_reg;
          rdata_next[ST_ABORT] = abrt_reg;
          rdata_next[ST_BADRW] = badrw_reg;
          rdata_next[ST_CNT_LSB +: 3] = bytec_reg;
        end
        REG_ADDR: rdata_next[15:0] = addr_view(addr_reg);
        REG_DATA: rdata_next = data_word;
        default: rdata_next = '0;
      endcase
    end
  end

  // All state registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= M_IDLE;
      go_reg <= 1'b0;
      pend_reg <= 1'b0;
      tx_reg <= 1'b1;
      stopm_reg <= 1'b0;
      bitc_reg <= '0;
      bytec_reg <= '0;
      shift_reg <= '0;
      addr_reg <= '0;
      ack_reg <= 1'b0;
      abort_pend_reg <= 1'b0;
      full_pend_reg <= 1'b0;
      for (int i = 0; i < MAX_BYTES; i++) begin
        mem_reg[i] <= '0;
      end
      ibi_en_reg <= CTRL_RESET[CTRL_IBI_EN];
      ack_en_reg <= CTRL_RESET[CTRL_ACK_EN];
      pec_reg <= CTRL_RESET[CTRL_PEC_EN];
      abort_after_reg <= CTRL_RESET[CTRL_ABORT_LSB +: 2];
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      abrt_reg <= 1'b0;
      badrw_reg <= 1'b0;
      busy_reg <= 1'b0;
      reg_rdata <= '0;
      host_data_line_out <= 1'b0;
    end else begin
      st_reg <= st_next;
      go_reg <= go_next;
      pend_reg <= pend_next;
      tx_reg <= tx_next;
      stopm_reg <= stopm_next;
      bitc_reg <= bitc_next;
      bytec_reg <= bytec_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      ack_reg <= ack_next;
      abort_pend_reg <= abort_pend_next;
      full_pend_reg <= full_pend_next;
      for (int i = 0; i < MAX_BYTES; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      ibi_en_reg <= ibi_en_next;
      ack_en_reg <= ack_en_next;
      pec_reg <= pec_next;
      abort_after_reg <= abort_after_next;
      done_reg <= done_next;
      nack_reg <= nack_next;
      abrt_reg <= abrt_next;
      badrw_reg <= badrw_next;
      busy_reg <= busy_next;
      reg_rdata <= rdata_next;
      host_data_line_out <= 1'b0; // Open drain: only the enable moves
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_NO_IBI_WHEN_OFF: assert property ((st_reg == M_IDLE && !ibi_en_reg) |=> st_reg == M_IDLE)
    else $error("request taken while interrupts off");
  AST_CLOCK_ANSWERS: assert property ((st_reg == M_IDLE && st_next == M_ADDR) |-> ##[1:6] !host_clock_line)
    else $error("clock not toggled after request");
  AST_ADDR_NINE: assert property ((st_reg == M_ADDR && eng_done && bitc_reg == 3'h7) |=> st_reg == M_ACK)
    else $error("ack slot not after eighth bit");
  AST_ACK_LEVEL: assert property (($rose(host_clock_line) && st_reg == M_ACK) |-> host_data_line_oe == ack_reg)
    else $error("ninth bit drive wrong");
  AST_DATA_NEEDS_ACK: assert property ((st_reg == M_DATA && $past(st_reg) == M_ACK) |-> ack_reg)
    else $error("payload read after nack");
  AST_NACK_STOP: assert property ((st_reg == M_ACK && eng_done && !ack_reg) |=> st_reg == M_STOP && nack_reg)
    else $error("nack not followed by stop");
  AST_LAST_T_STOP: assert property ((st_reg == M_TBIT && eng_done && !eng_rx) |=> st_reg == M_STOP)
    else $error("final transition bit not ended");
  AST_STOP_RELEASE: assert property ((st_reg == M_STOP && eng_done) |-> host_clock_line && !host_data_line_oe)
    else $error("stop left bus held");
  AST_ABORT_FLAG: assert property ((st_reg == M_STOP && eng_done && abort_pend_reg) |=> abrt_reg ##1 st_reg == M_IDLE)
    else $error("abort not reported");
  AST_BYTE_LIMIT: assert property ((st_reg == M_TBIT && eng_done && eng_rx && bytec_inc >= exp_bytes(pec_reg)) |=> st_reg == M_STOP)
    else $error("payload overran expected length");

  COV_FULL: cover property (st_reg == M_STOP && eng_done && full_pend_reg);
  COV_NACK: cover property (st_reg == M_ACK && eng_done && !ack_reg);
  COV_ABORT: cover property (st_reg == M_STOP && eng_done && abort_pend_reg);
  COV_HUB: cover property (st_reg == M_ACK && addr_reg[7:4] == HUB_DEVICE_CODE);

endmodule
`default_nettype wire

//--- core/hlib_pkg.sv
// Shared constants and types of the host-side interrupt receiver
package hlib_pkg;

  // ----------------------------------------------------------------
  // Register map of the controller's own register port
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;

  // Control fields
  localparam int CTRL_IBI_EN = 0;
  localparam int CTRL_ACK_EN = 1;
  localparam int CTRL_PEC_EN = 2;
  localparam int CTRL_ABORT_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h02;

  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_NACK = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_BADRW = 4;
  localparam int ST_CNT_LSB = 8;

  // Address fields of the request
  localparam int ADR_HUB_FLAG = 15;
  localparam logic [3:0] HUB_DEVICE_CODE = 4'ha;

  // ----------------------------------------------------------------
  // Payload and timing
  // ----------------------------------------------------------------
  localparam int MAX_BYTES = 4;
  localparam logic [2:0] BYTES_NO_PEC = 3'h3;
  localparam logic [2:0] BYTES_PEC = 3'h4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 160;
  localparam int SCL_HALF_CYC = SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_ACK, M_DATA, M_TBIT, M_STOP} hlib_state_t;

endpackage

//--- core/hlib_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module hlib_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '1;
      dout <= '1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule
`default_nettype wire

//--- core/hlib_bit_engine.sv
// One clock pulse on the host clock line with one data bit, or a stop
`timescale 1ns/1ns
`default_nettype none
module hlib_bit_engine import hlib_pkg::*; #(
  parameter int HALF = SCL_HALF_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic tx_bit,
  input wire logic stop_mode,
  input wire logic sda_s,
  output logic busy,
  output logic done,
  output logic rx_bit,
  output logic scl_out,
  output logic sda_oe
);

  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH, E_HOLD} hlib_eng_t;
  localparam int CW = $clog2(HALF) + 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  localparam logic [CW-1:0] MID = CW'(HALF / 2);

  hlib_eng_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic tx_reg, tx_next, stop_reg, stop_next;
  logic done_next, rx_next, scl_next, oe_next;

  assign busy = (st_reg != E_IDLE);

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  // Data changes mid low phase, sampled at end of high phase
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + CW'(1);
    tx_next = tx_reg;
    stop_next = stop_reg;
    done_next = 1'b0;
    rx_next = rx_bit;
    scl_next = scl_out;
    oe_next = sda_oe;
    unique case (st_reg)
      E_IDLE: begin
        cnt_next = '0;
        if (go) begin
          st_next = E_LOW;
          scl_next = 1'b0;
          tx_next = tx_bit;
          stop_next = stop_mode;
        end
      end
      E_LOW: begin
        if (cnt_reg == MID) begin
          oe_next = stop_reg | ~tx_reg;
        end
        if (cnt_reg == LAST) begin
          st_next = E_HIGH;
          scl_next = 1'b1;
          cnt_next = '0;
        end
      end
      E_HIGH: begin
        if (cnt_reg == LAST) begin
          cnt_next = '0;
          rx_next = sda_s;
          if (stop_reg) begin
            oe_next = 1'b0; // Data rises while clock high
            st_next = E_HOLD;
          end else begin
            st_next = E_IDLE;
            done_next = 1'b1;
          end
        end
      end
      E_HOLD: begin
        if (cnt_reg == LAST) begin
          st_next = E_IDLE;
          done_next = 1'b1;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= E_IDLE;
      cnt_reg <= '0;
      tx_reg <= 1'b1;
      stop_reg <= 1'b0;
      done <= 1'b0;
      rx_bit <= 1'b1;
      scl_out <= 1'b1;
      sda_oe <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      tx_reg <= tx_next;
      stop_reg <= stop_next;
      done <= done_next;
      rx_bit <= rx_next;
      scl_out <= scl_next;
      sda_oe <= oe_next;
    end
  end

endmodule
`default_nettype wire

//--- bench/hlib_hub_model.sv
// Hub with one local requester and one rival hub on the host data line
`timescale 1ns/1ns
`default_nettype none
module hlib_hub_model #(
  parameter int IDLE_CYC = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic allow,
  input wire logic ev_a,
  input wire logic ev_b,
  input wire logic [3:0] dev_a,
  input wire logic [2:0] grp_loc,
  input wire logic [2:0] grp_hub,
  input wire logic [2:0] grp_b,
  input wire logic grp_set,
  input wire logic pec_on,
  input wire logic [31:0] pay,
  output logic pull,
  output logic [3:0] pend_a,
  output logic [3:0] pend_b
);
  logic scl_d, sda_d, live, a_on, b_on, acked, sent;
  logic [7:0] adr_a, adr_b;
  int cnt, idle, p, nb;

  // Address the host sees; the hub swaps in its group until assigned
  assign adr_a = {dev_a, grp_set ? grp_loc : grp_hub, 1'b1};
  assign adr_b = {4'ha, grp_b, 1'b1};
  assign nb = pec_on ? 4 : 3;

  // Request, arbitration, payload and end of frame
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {scl_d, sda_d} <= 2'h3;
      {live, a_on, b_on, acked, sent, pull} <= 6'h0;
      pend_a <= 4'h0;
      pend_b <= 4'h0;
      cnt <= 0;
      idle <= 0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      idle <= (scl && scl_d && sda == sda_d) ? idle + 1 : 0;
      if (ev_a) pend_a <= 4'h1;
      if (ev_b) pend_b <= 4'h1;
      p = cnt - 9;
      if (!live) begin
        if (allow && (pend_a != 0 || pend_b != 0) && idle >= IDLE_CYC) begin
          live <= 1'b1;
          pull <= 1'b1;
          cnt <= 0;
          a_on <= pend_a != 0;
          b_on <= pend_b != 0;
          acked <= 1'b0;
          sent <= 1'b0;
        end
      end else if (cnt == 0 && !allow) begin
        live <= 1'b0;
        pull <= 1'b0;
      end else if (cnt != 0 && idle >= IDLE_CYC) begin
        // Quiet bus ends the frame; flags drop only after a whole payload
        live <= 1'b0;
        pull <= 1'b0;
        if (sent && a_on) pend_a <= 4'h0;
        if (sent && !a_on) pend_b <= 4'h0;
      end else if (scl_d && !scl) begin
        cnt <= cnt + 1;
        if (cnt < 8) begin
          pull <= (a_on && !adr_a[7-cnt]) || (b_on && !adr_b[7-cnt]);
        end else if (cnt >= 9 && acked && p < nb * 9) begin
          pull <= (p % 9 < 8) ? !pay[8 * (p / 9) + 7 - p % 9] : p / 9 == nb - 1;
          sent <= sent || p == nb * 9 - 1;
        end else begin
          pull <= 1'b0;
        end
      end else if (!scl_d && scl) begin
        if (cnt >= 1 && cnt <= 8 && !sda) begin
          a_on <= a_on && !adr_a[8-cnt];
          b_on <= b_on && !adr_b[8-cnt];
        end
        if (cnt == 9) acked <= !sda;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_hlib_host.sv
// Bench for the interrupt receiving host controller
`timescale 1ns/1ns
`default_nettype none
module tb_hlib_host import hlib_pkg::*;;
  logic clk, nrst, reg_wr, reg_rd, sda_out, sda_oe, scl, pull;
  logic allow, ev_a, ev_b, grp_set, pec_on;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, pay;
  logic [3:0] dev_a, pend_a, pend_b;
  logic [2:0] grp_loc, grp_hub, grp_b;
  wire logic sda;
  int error_cnt, num_checks;

  // Wired-and data line with a pull-up
  assign sda = !(pull || sda_oe);

  hlib_host #(.HALF(SCL_HALF_CYC)) dut (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_data_line_in(sda),
    .host_data_line_out(sda_out), .host_data_line_oe(sda_oe), .host_clock_line(scl)
  );
  hlib_hub_model hub (
    .clk(clk), .nrst(nrst), .scl(scl), .sda(sda), .allow(allow), .ev_a(ev_a), .ev_b(ev_b),
    .dev_a(dev_a), .grp_loc(grp_loc), .grp_hub(grp_hub), .grp_b(grp_b), .grp_set(grp_set),
    .pec_on(pec_on), .pay(pay), .pull(pull), .pend_a(pend_a), .pend_b(pend_b)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] ex_addr(input logic [3:0] d, input logic [2:0] g);
    return {16'h0, d == HUB_DEVICE_CODE, g, d, d, g, 1'b1};
  endfunction

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(n, d & m, e);
  endtask

  task automatic raise(input logic a, input logic b);
    @(posedge clk);
    ev_a <= a;
    ev_b <= b;
    @(posedge clk);
    ev_a <= 1'b0;
    ev_b <= 1'b0;
  endtask

  // Clear flags, set control, let the hub request and poll until a done, nack or abort flag is set and busy is clear
  task automatic frame(input logic [31:0] ctrl);
    int n;
    wr(REG_STATUS, 32'h1f);
    wr(REG_CTRL, ctrl);
    allow <= 1'b1;
    n = 0;
    v = 32'h0;
    while ((v[3:1] === 3'h0 || v[0] !== 1'b0) && n < 3000) begin
      rd(REG_STATUS, v);
      n++;
    end
    allow <= 1'b0;
    // Hub closes its frame and drops its flags only after a quiet bus
    repeat (40) @(posedge clk);
    if (n >= 3000) begin
      error_cnt++;
      $display("MISMATCH frame end expected done seen timeout");
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #300000;
    error_cnt++;
    $display("MISMATCH watchdog expected end seen timeout");
    stop_test();
  end

  // Test sequence
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    allow = 1'b0;
    ev_a = 1'b0;
    ev_b = 1'b0;
    dev_a = 4'h2;
    grp_loc = 3'h7;
    grp_hub = 3'h5;
    grp_b = 3'h6;
    grp_set = 1'b0;
    pec_on = 1'b0;
    pay = 32'h9ec3a500;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk("ctrl reset", REG_CTRL, '1, {26'h0, CTRL_RESET});
    chk("status reset", REG_STATUS, '1, 32'h0);
    wr(8'h10, 32'hff);
    chk("unmapped", 8'h10, '1, 32'h0);
    chk("ctrl kept", REG_CTRL, '1, 32'h2);
    $display("test registers ended");
    // Request while interrupts are off goes unanswered
    raise(1'b1, 1'b0);
    allow <= 1'b1;
    repeat (200) @(posedge clk);
    check("clock idle", {31'h0, scl}, 32'h1);
    check("data out", {31'h0, sda_out}, 32'h0);
    chk("status off", REG_STATUS, '1, 32'h0);
    allow <= 1'b0;
    $display("test disabled ended");
    // Local device, no group assigned yet
    frame(32'h3);
    chk("addr sub", REG_ADDR, '1, ex_addr(4'h2, 3'h5));
    chk("status ok", REG_STATUS, '1, 32'h302);
    chk("payload", REG_DATA, 32'hffffff, 32'hc3a500);
    check("pend clr", {28'h0, pend_a}, 32'h0);
    $display("test forward ended");
    // Assigned group passes through, check byte appended
    grp_set <= 1'b1;
    grp_loc <= 3'h3;
    pec_on <= 1'b1;
    raise(1'b1, 1'b0);
    frame(32'h7);
    chk("addr fwd", REG_ADDR, '1, ex_addr(4'h2, 3'h3));
    chk("status pec", REG_STATUS, '1, 32'h402);
    chk("payload pec", REG_DATA, '1, 32'h9ec3a500);
    grp_set <= 1'b0;
    pec_on <= 1'b0;
    $display("test assigned ended");
    // Refused, then retried and taken, then aborted mid payload
    raise(1'b1, 1'b0);
    frame(32'h1);
    chk("status nack", REG_STATUS, '1, 32'h4);
    check("pend kept", {28'h0, pend_a}, 32'h1);
    frame(32'h3);
    check("pend retry", {28'h0, pend_a}, 32'h0);
    raise(1'b1, 1'b0);
    frame(32'h13);
    chk("status abort", REG_STATUS, '1, 32'h108);
    check("pend abort", {28'h0, pend_a}, 32'h1);
    $display("test retry ended");
    // Two hubs contend; lower group wins, loser retries
    dev_a <= 4'ha;
    for (int i = 0; i < 2; i++) begin
      grp_hub <= i ? 3'h7 : 3'h3;
      grp_b <= i ? 3'h0 : 3'h6;
      raise(1'b1, 1'b1);
      frame(32'h3);
      chk("winner", REG_ADDR, '1, ex_addr(4'ha, i ? 3'h0 : 3'h3));
      check("loser", {28'h0, i ? pend_a : pend_b}, 32'h1);
      frame(32'h3);
      chk("retry", REG_ADDR, '1, ex_addr(4'ha, i ? 3'h7 : 3'h6));
    end
    $display("test arbitration ended");
    stop_test();
  end
endmodule
`default_nettype wire
